// file: pkg/pcc_pkg.sv
// Package with register map, field layout and reset values of the clock control block.
package pcc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 10;
  localparam logic [9:0] OFS_PLL_MAIN_CONTROL = 10'h010;
  localparam logic [9:0] OFS_BACKLASH_PULSE_CONTROL = 10'h017;
  localparam logic [9:0] OFS_OSC_CAL_CONTROL = 10'h018;
  localparam logic [9:0] OFS_PUMP_CURRENT_CONTROL = 10'h01e;
  localparam logic [9:0] OFS_OSC_DIVIDER_CONTROL = 10'h1e0;
  localparam logic [9:0] OFS_INPUT_SOURCE_SELECT = 10'h1e1;
  localparam logic [9:0] OFS_BLOCK_STATUS = 10'h1f0;
  localparam logic [9:0] OFS_SETTINGS_UPDATE_STROBE = 10'h232;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PWR_LSB = 0;
  localparam int CPM_LSB = 4;
  localparam int POL_BIT = 7;
  localparam int ABL_LSB = 0;
  localparam int CAL_BIT = 0;
  localparam int ICP_LSB = 0;
  localparam int DIV_LSB = 0;
  localparam int BYPASS_BIT = 0;
  localparam int SRC_BIT = 1;
  localparam int UPD_BIT = 0;

  // ****************************************************************
  // Field values and reset values
  // ****************************************************************
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_ASYNC_PD = 2'h1;
  localparam logic [2:0] CPM_HIZ = 3'h0;
  localparam logic [2:0] CPM_FORCE_UP = 3'h1;
  localparam logic [2:0] CPM_FORCE_DN = 3'h2;
  localparam logic [2:0] CPM_NORMAL = 3'h3;
  localparam logic [7:0] UPD_VALUE = 8'h01;
  localparam logic [2:0] DIV_BASE = 3'h2;
  localparam logic [2:0] DIV_CODE_MAX = 3'h4;
  localparam logic [7:0] RST_PLL_MAIN_CONTROL = 8'h01;
  localparam logic [7:0] RST_BACKLASH_PULSE_CONTROL = 8'h00;
  localparam logic [7:0] RST_OSC_CAL_CONTROL = 8'h00;
  localparam logic [7:0] RST_PUMP_CURRENT_CONTROL = 8'h00;
  localparam logic [7:0] RST_OSC_DIVIDER_CONTROL = 8'h02;
  localparam logic [7:0] RST_INPUT_SOURCE_SELECT = 8'h00;
  localparam int CAL_CNT_W = 8;

endpackage

// file: pkg/pcc_pfd_if.sv
// Interface between the control core and the phase detector.
`timescale 1ns/10ps
`default_nettype none
interface pcc_pfd_if;
  logic ref_evt;
  logic fb_evt;
  logic en;
  logic [1:0] abl_sel;
  logic up;
  logic dn;
  modport det (input ref_evt, input fb_evt, input en, input abl_sel, output up, output dn);
  modport ctl (output ref_evt, output fb_evt, output en, output abl_sel, input up, input dn);
endinterface
`default_nettype wire

// file: verilog/pcc_div.sv
// Pulse divider that passes one source tick in every two to six.
`timescale 1ns/10ps
`default_nettype none
module pcc_div
  import pcc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic [2:0] ratio_code_in,
  output logic pulse_out
);

  typedef struct packed {
    logic [2:0] cnt;
    logic pulse;
  } pcc_div_st_t;

  pcc_div_st_t st_reg;
  pcc_div_st_t st_next;
  logic [2:0] last;

  // Codes above the largest ratio are held at divide-by-6.
  assign last = (ratio_code_in > DIV_CODE_MAX) ? (DIV_CODE_MAX + DIV_BASE - 3'h1)
                                               : (ratio_code_in + DIV_BASE - 3'h1);

  always_comb begin
    st_next = st_reg;
    st_next.pulse = 1'b0;
    if (tick_in) begin
      if (st_reg.cnt >= last) begin
        st_next.cnt = 3'h0;
        st_next.pulse = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse_out = st_reg.pulse;

endmodule
`default_nettype wire

// file: verilog/pcc_pfd.sv
// Phase frequency detector with a programmable antibacklash overlap.
`timescale 1ns/10ps
`default_nettype none
module pcc_pfd
  import pcc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  pcc_pfd_if.det pfd
);

  typedef struct packed {
    logic up;
    logic dn;
    logic [1:0] abl_cnt;
  } pcc_pfd_st_t;

  pcc_pfd_st_t st_reg;
  pcc_pfd_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (!pfd.en) begin
      st_next = '0;
    end else begin
      // A reference edge asks for more frequency, a feedback edge for less.
      st_next.up = st_reg.up | pfd.ref_evt; // [R7]
      st_next.dn = st_reg.dn | pfd.fb_evt; // [R7]
      // Both outputs overlap for abl_sel+1 cycles before reset, so no dead zone.
      if (st_reg.up && st_reg.dn) begin
        if (st_reg.abl_cnt == pfd.abl_sel) begin // [R8]
          st_next.up = pfd.ref_evt;
          st_next.dn = pfd.fb_evt;
          st_next.abl_cnt = 2'h0;
        end else begin
          st_next.abl_cnt = st_reg.abl_cnt + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pfd.up = st_reg.up;
  assign pfd.dn = st_reg.dn;

endmodule
`default_nettype wire

// file: verilog/pcc_top.sv
// Clock control core: staged registers, update transfer, routing, pump and calibration.
//
// Behaviour
// R1: power field 01b powers down, 00b runs.
// R2: bypass bit feeds distribution straight from source.
// R3: source bit 0 selects external clock input.
// R4: polarity bit 0 positive, 1 negative.
// R5: staged values act only after update write.
// R6: software sets normal power and bypass below limit.
// R7: detector compares reference and feedback divider outputs.
// R8: two-bit field sets antibacklash pulse width.
// R9: pump mode: high-z, normal, force up, down.
// R10: pump current in eight equal steps.
// R11: normal mode pumps per detector result.
// R12: polarity applies only with external oscillator.
// R13: software calibrates at setup and frequency change.
// R14: calibration needs reference and toggling divider.
// R15: calibration bit plus update starts a run.
// R16: source bit 1 selects internal oscillator.
// R17: three-bit field sets divide ratio two to six.
// R18: update strobe clears itself after transfer.
`timescale 1ns/10ps
`default_nettype none
module pcc_top
  import pcc_pkg::*;
#(
  parameter int CAL_REF_EDGES = 16
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  input wire logic ref_div_in,
  input wire logic fb_div_in,
  input wire logic ext_clk_in,
  input wire logic osc_clk_in,
  output logic pll_off_out,
  output logic pump_up_out,
  output logic pump_dn_out,
  output logic pump_hiz_out,
  output logic [2:0] pump_current_out,
  output logic osc_sel_out,
  output logic dist_tick_out,
  output logic cal_busy_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [7:0] main_ctl;
    logic [7:0] abl_ctl;
    logic [7:0] cal_ctl;
    logic [7:0] icp_ctl;
    logic [7:0] div_ctl;
    logic [7:0] src_ctl;
    logic upd;
    logic [7:0] a_main;
    logic [1:0] a_abl;
    logic a_cal;
    logic [2:0] a_icp;
    logic [2:0] a_div;
    logic a_bypass;
    logic a_src;
    logic cal_busy;
    logic cal_done;
    logic div_seen;
    logic [CAL_CNT_W-1:0] cal_cnt;
    logic [7:0] rdata;
    logic pll_off;
    logic up;
    logic dn;
    logic hiz;
    logic dist_tick;
  } pcc_st_t;

  pcc_st_t st_reg;
  pcc_st_t st_next;

  pcc_pfd_if pfd_bus ();

  logic [3:0] rise;
  logic src_tick;
  logic div_pulse;
  logic run;
  logic swap;
  logic [2:0] cp_mode;
  logic [7:0] status;
  logic [CAL_CNT_W-1:0] cal_last;

  // Bit order of the synchroniser: 0 reference, 1 feedback, 2 external, 3 oscillator.
  assign rise = st_reg.s2 & ~st_reg.s3;
  assign src_tick = st_reg.a_src ? rise[3] : rise[2]; // [R3] [R16]
  assign run = (st_reg.a_main[PWR_LSB+:2] == PWR_NORMAL); // [R1]
  assign cp_mode = st_reg.a_main[CPM_LSB+:3];
  // Polarity is honoured only while the external clock is in the loop.
  assign swap = st_reg.a_main[POL_BIT] && !st_reg.a_src; // [R4] [R12]
  assign cal_last = CAL_CNT_W'(CAL_REF_EDGES - 1);
  assign status = {2'h0, st_reg.a_bypass, st_reg.a_src, st_reg.upd,
                   st_reg.cal_done, st_reg.cal_busy, st_reg.pll_off};

  // ****************************************************************
  // Detector and divider
  // ****************************************************************
  assign pfd_bus.ref_evt = rise[0];
  assign pfd_bus.fb_evt = rise[1];
  assign pfd_bus.en = run && !st_reg.cal_busy;
  assign pfd_bus.abl_sel = st_reg.a_abl; // [R8]

  pcc_pfd u_pfd (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .pfd(pfd_bus.det)
  );

  pcc_div u_div (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .tick_in(src_tick),
    .ratio_code_in(st_reg.a_div), // [R17]
    .pulse_out(div_pulse)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.s1 = {osc_clk_in, ext_clk_in, fb_div_in, ref_div_in};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;

    // Staged settings move into use one cycle after the update write.
    if (st_reg.upd) begin
      st_next.a_main = st_reg.main_ctl; // [R5]
      st_next.a_abl = st_reg.abl_ctl[ABL_LSB+:2];
      st_next.a_cal = st_reg.cal_ctl[CAL_BIT];
      st_next.a_icp = st_reg.icp_ctl[ICP_LSB+:3]; // [R10]
      st_next.a_div = st_reg.div_ctl[DIV_LSB+:3];
      st_next.a_bypass = st_reg.src_ctl[BYPASS_BIT];
      st_next.a_src = st_reg.src_ctl[SRC_BIT];
      st_next.upd = 1'b0; // [R18]
      // A run starts on the calibration bit going from 0 to 1 in use.
      if (st_reg.cal_ctl[CAL_BIT] && !st_reg.a_cal) begin // [R15]
        st_next.cal_busy = 1'b1;
        st_next.cal_done = 1'b0;
        st_next.cal_cnt = '0;
        st_next.div_seen = 1'b0;
      end
    end

    // Register writes; an update write beside a transfer wins over the clear.
    if (wr_en_in) begin
      case (addr_in)
        OFS_PLL_MAIN_CONTROL: st_next.main_ctl = wr_data_in;
        OFS_BACKLASH_PULSE_CONTROL: st_next.abl_ctl = {6'h0, wr_data_in[ABL_LSB+:2]};
        OFS_OSC_CAL_CONTROL: st_next.cal_ctl = {7'h0, wr_data_in[CAL_BIT]};
        OFS_PUMP_CURRENT_CONTROL: st_next.icp_ctl = {5'h0, wr_data_in[ICP_LSB+:3]};
        OFS_OSC_DIVIDER_CONTROL: st_next.div_ctl = {5'h0, wr_data_in[DIV_LSB+:3]};
        OFS_INPUT_SOURCE_SELECT: st_next.src_ctl = {6'h0, wr_data_in[SRC_BIT:BYPASS_BIT]};
        OFS_SETTINGS_UPDATE_STROBE: begin
          if (wr_data_in == UPD_VALUE) begin
            st_next.upd = 1'b1; // [R5]
          end
        end
        default: begin
        end
      endcase
    end

    // Calibration counts reference edges, each preceded by a divider tick.
    if (st_reg.cal_busy && !st_reg.upd) begin
      if (div_pulse) begin
        st_next.div_seen = 1'b1;
      end
      if (rise[0]) begin
        st_next.div_seen = div_pulse;
        if (st_reg.div_seen) begin // [R14]
          if (st_reg.cal_cnt == cal_last) begin
            st_next.cal_busy = 1'b0;
            st_next.cal_done = 1'b1;
          end else begin
            st_next.cal_cnt = st_reg.cal_cnt + CAL_CNT_W'(1);
          end
        end
      end
    end

    // Charge pump drive.
    st_next.pll_off = !run; // [R1]
    st_next.up = 1'b0;
    st_next.dn = 1'b0;
    st_next.hiz = 1'b1;
    if (run && !st_reg.cal_busy) begin
      case (cp_mode)
        CPM_NORMAL: begin
          st_next.hiz = 1'b0;
          st_next.up = swap ? pfd_bus.dn : pfd_bus.up; // [R11] [R4]
          st_next.dn = swap ? pfd_bus.up : pfd_bus.dn; // [R11] [R4]
        end
        CPM_FORCE_UP: begin
          st_next.hiz = 1'b0;
          st_next.up = 1'b1; // [R9]
        end
        CPM_FORCE_DN: begin
          st_next.hiz = 1'b0;
          st_next.dn = 1'b1; // [R9]
        end
        default: begin
          st_next.hiz = 1'b1; // [R9]
        end
      endcase
    end

    // Distribution tick, straight from the source or through the divider.
    st_next.dist_tick = st_reg.a_bypass ? src_tick : div_pulse; // [R2]

    // Read data stand only in the cycle after the read strobe.
    st_next.rdata = 8'h00;
    if (rd_en_in) begin
      case (addr_in)
        OFS_PLL_MAIN_CONTROL: st_next.rdata = st_reg.main_ctl;
        OFS_BACKLASH_PULSE_CONTROL: st_next.rdata = st_reg.abl_ctl;
        OFS_OSC_CAL_CONTROL: st_next.rdata = st_reg.cal_ctl;
        OFS_PUMP_CURRENT_CONTROL: st_next.rdata = st_reg.icp_ctl;
        OFS_OSC_DIVIDER_CONTROL: st_next.rdata = st_reg.div_ctl;
        OFS_INPUT_SOURCE_SELECT: st_next.rdata = st_reg.src_ctl;
        OFS_SETTINGS_UPDATE_STROBE: st_next.rdata = {7'h0, st_reg.upd};
        OFS_BLOCK_STATUS: st_next.rdata = status;
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.main_ctl <= RST_PLL_MAIN_CONTROL;
      st_reg.abl_ctl <= RST_BACKLASH_PULSE_CONTROL;
      st_reg.cal_ctl <= RST_OSC_CAL_CONTROL;
      st_reg.icp_ctl <= RST_PUMP_CURRENT_CONTROL;
      st_reg.div_ctl <= RST_OSC_DIVIDER_CONTROL;
      st_reg.src_ctl <= RST_INPUT_SOURCE_SELECT;
      st_reg.a_main <= RST_PLL_MAIN_CONTROL;
      st_reg.a_div <= RST_OSC_DIVIDER_CONTROL[2:0];
      st_reg.pll_off <= 1'b1;
      st_reg.hiz <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data_out = st_reg.rdata;
  assign pll_off_out = st_reg.pll_off;
  assign pump_up_out = st_reg.up;
  assign pump_dn_out = st_reg.dn;
  assign pump_hiz_out = st_reg.hiz;
  assign pump_current_out = st_reg.a_icp;
  assign osc_sel_out = st_reg.a_src;
  assign dist_tick_out = st_reg.dist_tick;
  assign cal_busy_out = st_reg.cal_busy;

endmodule
`default_nettype wire

// file: verif/pcc_top_chk.sv
// Concurrent checks on the ports of the clock control block.
`timescale 1ns/10ps
`default_nettype none
module pcc_top_chk
  import pcc_pkg::*;
#(
  parameter int CAL_REF_EDGES = 16
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] rd_data_out,
  input wire logic ref_div_in,
  input wire logic fb_div_in,
  input wire logic ext_clk_in,
  input wire logic osc_clk_in,
  input wire logic pll_off_out,
  input wire logic pump_up_out,
  input wire logic pump_dn_out,
  input wire logic pump_hiz_out,
  input wire logic [2:0] pump_current_out,
  input wire logic osc_sel_out,
  input wire logic dist_tick_out,
  input wire logic cal_busy_out
);
  // ********************
  // Update write decode
  // ********************
  logic upd_wr;
  assign upd_wr = wr_en_in && addr_in == OFS_SETTINGS_UPDATE_STROBE && wr_data_in == UPD_VALUE;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  a_read_idle_zero: assert property (!$past(rd_en_in) |-> rd_data_out == 8'h00)
    else $error("read data not zero outside read slot");
  a_power_staged: assert property ($changed(pll_off_out) |-> $past(upd_wr, 3))
    else $error("power state changed without update");
  // Source and current come straight from the active settings, a cycle ahead of the pump.
  a_source_staged: assert property ($changed(osc_sel_out) |-> $past(upd_wr, 2))
    else $error("source select changed without update");
  a_current_staged: assert property ($changed(pump_current_out) |-> $past(upd_wr, 2))
    else $error("pump current changed without update");
  a_hiz_quiet: assert property (pump_hiz_out |-> !pump_up_out && !pump_dn_out)
    else $error("pump drives while high impedance");
  a_off_hiz: assert property (pll_off_out && $past(pll_off_out) |-> pump_hiz_out)
    else $error("pump active while powered down");
  a_cal_hiz: assert property (cal_busy_out && $past(cal_busy_out) |-> pump_hiz_out)
    else $error("pump active during calibration");
  a_cal_start: assert property ($rose(cal_busy_out) |->
    $past(upd_wr, 2) || $past(upd_wr, 3) || $past(upd_wr, 4))
    else $error("calibration started without update");
  a_overlap_bound: assert property ($rose(pump_up_out && pump_dn_out) |->
    ##[1:4] !(pump_up_out && pump_dn_out))
    else $error("pump overlap too long");
  a_tick_single: assert property (dist_tick_out |=> !dist_tick_out)
    else $error("distribution tick longer than one cycle");
endmodule
`default_nettype wire

// file: verif/pll_config_control_test.sv
// Self-checking bench for the clock control block.
`timescale 1ns/10ps
`default_nettype none
module pll_config_control_test
  import pcc_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] addr_in = 10'h000;
  logic [7:0] wr_data_in = 8'h00;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic ref_div_in = 1'b0;
  logic fb_div_in = 1'b0;
  logic ext_clk_in = 1'b0;
  logic osc_clk_in = 1'b0;
  logic [7:0] rd_data_out;
  logic pll_off_out, pump_up_out, pump_dn_out, pump_hiz_out;
  logic osc_sel_out, dist_tick_out, cal_busy_out;
  logic [2:0] pump_current_out;
  logic [2:0] src_cnt = 3'h0;
  logic [7:0] rdv;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  int w;
  logic [9:0] ra [9] = '{OFS_PLL_MAIN_CONTROL, OFS_BACKLASH_PULSE_CONTROL, OFS_OSC_CAL_CONTROL,
    OFS_PUMP_CURRENT_CONTROL, OFS_OSC_DIVIDER_CONTROL, OFS_INPUT_SOURCE_SELECT,
    OFS_SETTINGS_UPDATE_STROBE, OFS_BLOCK_STATUS, 10'h3ff};
  logic [7:0] rv [9] = '{RST_PLL_MAIN_CONTROL, RST_BACKLASH_PULSE_CONTROL, RST_OSC_CAL_CONTROL,
    RST_PUMP_CURRENT_CONTROL, RST_OSC_DIVIDER_CONTROL, RST_INPUT_SOURCE_SELECT,
    8'h00, 8'h01, 8'h00};

  always #10 core_clk_in = ~core_clk_in;

  // External clock runs at a quarter, oscillator at an eighth of the core rate.
  always @(posedge core_clk_in) begin
    src_cnt <= src_cnt + 3'h1;
    ext_clk_in <= src_cnt[1];
    osc_clk_in <= src_cnt[2];
  end

  pcc_top #(.CAL_REF_EDGES(2)) dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .ref_div_in(ref_div_in), .fb_div_in(fb_div_in),
    .ext_clk_in(ext_clk_in), .osc_clk_in(osc_clk_in), .pll_off_out(pll_off_out),
    .pump_up_out(pump_up_out), .pump_dn_out(pump_dn_out), .pump_hiz_out(pump_hiz_out),
    .pump_current_out(pump_current_out), .osc_sel_out(osc_sel_out),
    .dist_tick_out(dist_tick_out), .cal_busy_out(cal_busy_out));

  // ********************
  // Access and check tasks
  // ********************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge core_clk_in);
    wr_en_in <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    @(posedge core_clk_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge core_clk_in);
    rd_en_in <= 1'b0;
    #1 v = rd_data_out;
  endtask

  task automatic upd;
    wr(OFS_SETTINGS_UPDATE_STROBE, UPD_VALUE);
    repeat (4) @(posedge core_clk_in);
    #1;
  endtask

  task automatic pulse(input logic fb);
    @(posedge core_clk_in);
    if (fb) fb_div_in <= 1'b1;
    else ref_div_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    fb_div_in <= 1'b0;
    ref_div_in <= 1'b0;
  endtask

  function automatic logic [7:0] near(input int seen, input int want);
    return (seen >= want - 1 && seen <= want + 1) ? want[7:0] : seen[7:0];
  endfunction

  task automatic close_out;
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_errors++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(ra[i], rdv);
      check(rdv, rv[i]);
    end
    check({2'h0, pll_off_out, pump_hiz_out, pump_up_out, pump_dn_out, osc_sel_out,
      cal_busy_out}, 8'h30);
    $display("test reset done");
    wr(OFS_PLL_MAIN_CONTROL, 8'h30);
    wr(OFS_PUMP_CURRENT_CONTROL, 8'h07);
    wr(OFS_SETTINGS_UPDATE_STROBE, 8'h02);
    wr(10'h3ff, 8'hff);
    repeat (4) @(posedge core_clk_in);
    #1 check({7'h0, pll_off_out}, 8'h01);
    rd(OFS_PLL_MAIN_CONTROL, rdv);
    check(rdv, 8'h30);
    rd(10'h3ff, rdv);
    check(rdv, 8'h00);
    upd();
    check({6'h0, pll_off_out, pump_hiz_out}, 8'h00);
    check({5'h0, pump_current_out}, 8'h07);
    rd(OFS_SETTINGS_UPDATE_STROBE, rdv);
    check(rdv, 8'h00);
    wr(OFS_PLL_MAIN_CONTROL, 8'h31);
    upd();
    check({6'h0, pll_off_out, pump_hiz_out}, 8'h03);
    wr(OFS_PLL_MAIN_CONTROL, 8'h32);
    upd();
    check({6'h0, pll_off_out, pump_hiz_out}, 8'h03);
    $display("test staging done");
    for (int m = 0; m < 8; m++) begin
      wr(OFS_PLL_MAIN_CONTROL, {1'b0, m[2:0], 4'h0});
      upd();
      check({5'h0, pump_hiz_out, pump_up_out, pump_dn_out},
        {5'h0, m == 0 || m > 3, m == 1, m == 2});
    end
    $display("test pump modes done");
    for (int k = 0; k < 3; k++) begin
      wr(OFS_INPUT_SOURCE_SELECT, {6'h0, k == 2, 1'b0});
      wr(OFS_BACKLASH_PULSE_CONTROL, {6'h0, k[0], k[0]});
      wr(OFS_PLL_MAIN_CONTROL, {k > 0, 3'h3, 4'h0});
      upd();
      check({7'h0, osc_sel_out}, {7'h0, k == 2});
      pulse(1'b0);
      repeat (4) @(posedge core_clk_in);
      #1 check({6'h0, pump_up_out, pump_dn_out}, k == 1 ? 8'h01 : 8'h02);
      n = 0;
      fork
        pulse(1'b1);
        repeat (24) begin
          @(posedge core_clk_in);
          #1 n += int'(pump_up_out && pump_dn_out);
        end
      join
      check(n[7:0], k == 1 ? 8'h04 : 8'h01);
      check({6'h0, pump_up_out, pump_dn_out}, 8'h00);
    end
    $display("test detector done");
    for (int c = 0; c < 8; c++) begin
      wr(OFS_INPUT_SOURCE_SELECT, c == 6 ? 8'h01 : c == 7 ? 8'h03 : 8'h00);
      wr(OFS_OSC_DIVIDER_CONTROL, c[7:0]);
      upd();
      n = 0;
      repeat (240) begin
        @(posedge core_clk_in);
        #1 n += int'(dist_tick_out);
      end
      w = c == 7 ? 30 : c == 6 ? 60 : 60 / (c > 4 ? 6 : c + 2);
      check(near(n, w), w[7:0]);
    end
    $display("test distribution done");
    wr(OFS_INPUT_SOURCE_SELECT, 8'h02);
    wr(OFS_OSC_CAL_CONTROL, 8'h01);
    upd();
    check({6'h0, cal_busy_out, pump_hiz_out}, 8'h03);
    repeat (4) begin
      repeat (36) @(posedge core_clk_in);
      pulse(1'b0);
    end
    repeat (8) @(posedge core_clk_in);
    #1 check({7'h0, cal_busy_out}, 8'h00);
    rd(OFS_BLOCK_STATUS, rdv);
    check(rdv & 8'h06, 8'h04);
    $display("test calibration done");
    close_out();
  end
endmodule

bind pcc_top pcc_top_chk #(.CAL_REF_EDGES(CAL_REF_EDGES)) chk (.core_clk_in(core_clk_in),
  .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
  .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .ref_div_in(ref_div_in),
  .fb_div_in(fb_div_in), .ext_clk_in(ext_clk_in), .osc_clk_in(osc_clk_in),
  .pll_off_out(pll_off_out), .pump_up_out(pump_up_out), .pump_dn_out(pump_dn_out),
  .pump_hiz_out(pump_hiz_out), .pump_current_out(pump_current_out),
  .osc_sel_out(osc_sel_out), .dist_tick_out(dist_tick_out), .cal_busy_out(cal_busy_out));
`default_nettype wire
